// >>> rtl/multifunction_pin_select.sv
module multifunction_pin_select (
   input wire logic clock_i,
   input wire logic resetn_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [7:0] reg_rdata_o,
   // core side
   input wire pin_select_pkg::core_out_s core_out_i,
   output pin_select_pkg::core_in_s core_in_o,
   input wire logic slow_clock_active_i,
   input wire logic clock_stop_uses_speed_i,
   input wire logic mouse_enable_i,
   input wire logic mouse_clock_drive_low_i,
   input wire logic mouse_data_drive_low_i,
   output logic mouse_clock_level_o,
   output logic mouse_data_level_o,
   input wire logic [15:10] cycle_addr_i,
   input wire logic expansion_cycle_active_i,
   input wire logic io_cycle_i,
   output logic io_to_onboard_bus_o,
   // pins
   input wire logic local_claim_0_n_i,
   input wire logic local_claim_1_n_i,
   input wire logic local_claim_2_n_i,
   input wire logic multi_pin_a_i,
   input wire logic dma_grant_n_i,
   input wire logic mouse_clock_line_i,
   output logic mouse_clock_line_o,
   output logic mouse_clock_line_oe_o,
   input wire logic mouse_data_line_i,
   output logic mouse_data_line_o,
   output logic mouse_data_line_oe_o,
   output logic multi_pin_b_o,
   output logic multi_pin_c_o,
   output logic multi_pin_d_o,
   output logic row_strobe_6_n_o,
   output logic row_strobe_7_n_o,
   output logic cache_flush_n_o,
   output logic clock_stop_n_o,
   output logic slow_clock_select_o
);
   localparam int NPIN = 6;

   logic [7:0] select_a_reg;
   logic [7:0] select_b_reg;
   logic [7:0] gen_out_reg;
   logic [7:0] rdata_reg;
   logic [NPIN-1:0] pin_meta_reg;
   logic [NPIN-1:0] pin_sync_reg;

   // two-flop synchronisers for all input pins
   logic [NPIN-1:0] pin_raw;
   assign pin_raw = {mouse_data_line_i, mouse_clock_line_i, multi_pin_a_i,
                     local_claim_2_n_i, local_claim_1_n_i, local_claim_0_n_i};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         always_ff @(posedge clock_i or negedge resetn_i) begin
            if (!resetn_i) begin
               pin_meta_reg[gi] <= 1'b1;
               pin_sync_reg[gi] <= 1'b1;
            end else begin
               pin_meta_reg[gi] <= pin_raw[gi];
               pin_sync_reg[gi] <= pin_meta_reg[gi];
            end
         end
      end
   endgenerate

   logic claim0_s, claim1_s, claim2_s, pin_a_s, mclk_s, mouse_data_line_s;
   assign claim0_s = pin_sync_reg[0];
   assign claim1_s = pin_sync_reg[1];
   assign claim2_s = pin_sync_reg[2];
   assign pin_a_s = pin_sync_reg[3];
   assign mclk_s = pin_sync_reg[4];
   assign mouse_data_line_s = pin_sync_reg[5];

   // register writes
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         select_a_reg <= pin_select_pkg::SELECT_A_RESET;
         select_b_reg <= pin_select_pkg::SELECT_B_RESET;
         gen_out_reg <= pin_select_pkg::GEN_OUT_RESET;
      end else if (reg_write_i) begin
         case (reg_addr_i)
            pin_select_pkg::SELECT_A_IDX: select_a_reg <= reg_wdata_i;
            pin_select_pkg::SELECT_B_IDX: select_b_reg <= reg_wdata_i;
            pin_select_pkg::GEN_OUT_IDX: gen_out_reg <= reg_wdata_i;
            default: ;
         endcase
      end
   end

   // general input snapshot of live levels
   logic [7:0] gen_in;
   always_comb begin
      gen_in = 8'h00;
      gen_in[pin_select_pkg::GI_CLAIM0_POS] = claim0_s;
      gen_in[pin_select_pkg::GI_CLAIM1_POS] = claim1_s;
      gen_in[pin_select_pkg::GI_PIN_A_POS] = pin_a_s;
      gen_in[pin_select_pkg::GI_MCLK_POS] = mclk_s;
      gen_in[pin_select_pkg::GI_MOUSE_DATA_LINE_POS] = mouse_data_line_s;
   end

   // read data one cycle later, zero on unmapped index
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_reg <= 8'h00;
      end else if (reg_read_i) begin
         case (reg_addr_i)
            pin_select_pkg::SELECT_A_IDX: rdata_reg <= select_a_reg;
            pin_select_pkg::SELECT_B_IDX: rdata_reg <= select_b_reg;
            pin_select_pkg::GEN_OUT_IDX: rdata_reg <= gen_out_reg;
            pin_select_pkg::GEN_IN_IDX: rdata_reg <= gen_in;
            default: rdata_reg <= 8'h00;
         endcase
      end else begin
         rdata_reg <= 8'h00;
      end
   end
   assign reg_rdata_o = rdata_reg;

   // select fields
   pin_select_pkg::sel_code_e sel_claim1, sel_claim2, sel_pin_a, sel_pin_b;
   pin_select_pkg::sel_code_e sel_pin_c, sel_pin_d, sel_row6, sel_row7, sel_flush;
   assign sel_claim1 = pin_select_pkg::sel_code_e'(
      select_a_reg[pin_select_pkg::CLAIM1_SEL_POS +: 2]);
   assign sel_claim2 = pin_select_pkg::sel_code_e'(
      select_a_reg[pin_select_pkg::CLAIM2_SEL_POS +: 2]);
   assign sel_pin_a = pin_select_pkg::sel_code_e'(
      select_a_reg[pin_select_pkg::PIN_A_SEL_POS +: 2]);
   assign sel_pin_b = pin_select_pkg::sel_code_e'(
      select_a_reg[pin_select_pkg::PIN_B_SEL_POS +: 2]);
   assign sel_row6 = pin_select_pkg::sel_code_e'(
      select_b_reg[pin_select_pkg::ROW6_SEL_POS +: 2]);
   assign sel_row7 = pin_select_pkg::sel_code_e'(
      select_b_reg[pin_select_pkg::ROW7_SEL_POS +: 2]);
   assign sel_pin_c = pin_select_pkg::sel_code_e'(
      select_b_reg[pin_select_pkg::PIN_C_SEL_POS +: 2]);
   assign sel_pin_d = pin_select_pkg::sel_code_e'(
      select_b_reg[pin_select_pkg::PIN_D_SEL_POS +: 2]);
   assign sel_flush = pin_select_pkg::sel_code_e'(
      gen_out_reg[pin_select_pkg::FLUSH_SEL_POS +: 2]);

   // input pin decode
   always_comb begin
      core_in_o = '0;
      core_in_o.keyboard_lock = 1'b1;
      core_in_o.onboard_io_route_n = 1'b1;
      // claim inputs active low, merged into one claim
      core_in_o.local_claim = !claim0_s
         || (sel_claim1 == pin_select_pkg::SEL_F2 && !claim1_s)
         || (sel_claim2 == pin_select_pkg::SEL_F2 && !claim2_s);
      if (sel_claim1 == pin_select_pkg::SEL_F3) begin
         core_in_o.time_base = claim1_s;
         core_in_o.time_base_valid = 1'b1;
      end else if (sel_pin_a == pin_select_pkg::SEL_F2) begin
         core_in_o.time_base = pin_a_s;
         core_in_o.time_base_valid = 1'b1;
      end
      if (sel_claim2 == pin_select_pkg::SEL_F3) begin
         core_in_o.keyboard_lock = claim2_s;
      end
      if (sel_claim2 == pin_select_pkg::SEL_F4) begin
         core_in_o.wake_event_1 = claim2_s;
      end
      if (sel_pin_a == pin_select_pkg::SEL_F3) begin
         core_in_o.onboard_io_route_n = pin_a_s;
      end
      if (sel_pin_a == pin_select_pkg::SEL_F4) begin
         core_in_o.wake_event_0 = pin_a_s;
      end
   end

   // onboard routing affects io cycles only
   assign io_to_onboard_bus_o = io_cycle_i && !core_in_o.onboard_io_route_n;

   // shared combinational functions
   logic companion_io_select_n, expansion_bus_enable;
   logic mem_window_select_0_n, mem_window_select_1_n;
   assign companion_io_select_n = |cycle_addr_i;
   // dma grant is a pin, taken after the synchroniser
   logic [1:0] grant_sync_reg;
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         grant_sync_reg <= 2'b11;
      end else begin
         grant_sync_reg <= {grant_sync_reg[0], dma_grant_n_i};
      end
   end
   assign expansion_bus_enable = expansion_cycle_active_i || !grant_sync_reg[1];
   assign mem_window_select_0_n = !core_out_i.mem_decode_0;
   assign mem_window_select_1_n = !core_out_i.mem_decode_1;
   assign slow_clock_select_o = slow_clock_active_i;

   // output pin multiplexers
   always_comb begin
      case (sel_pin_b)
         pin_select_pkg::SEL_F1: multi_pin_b_o = core_out_i.writeback_policy;
         pin_select_pkg::SEL_F2: multi_pin_b_o = expansion_bus_enable;
         pin_select_pkg::SEL_F3: multi_pin_b_o = core_out_i.mouse_interrupt;
         default: multi_pin_b_o = gen_out_reg[pin_select_pkg::GO_PIN_B_POS];
      endcase
      case (sel_pin_c)
         pin_select_pkg::SEL_F1: multi_pin_c_o = core_out_i.write_protect_n;
         pin_select_pkg::SEL_F2: multi_pin_c_o = core_out_i.cache_ram_select;
         pin_select_pkg::SEL_F3: multi_pin_c_o = core_out_i.io_window_select_0_n;
         default: multi_pin_c_o = gen_out_reg[pin_select_pkg::GO_PIN_C_POS];
      endcase
      case (sel_pin_d)
         pin_select_pkg::SEL_F1: multi_pin_d_o = core_out_i.dram_buffer_select_n;
         pin_select_pkg::SEL_F2: multi_pin_d_o = expansion_bus_enable;
         pin_select_pkg::SEL_F3: multi_pin_d_o = core_out_i.io_window_select_1_n;
         default: multi_pin_d_o = gen_out_reg[pin_select_pkg::GO_PIN_D_POS];
      endcase
      case (sel_row6)
         pin_select_pkg::SEL_F1: row_strobe_6_n_o = core_out_i.row_strobe_6_n;
         pin_select_pkg::SEL_F2: row_strobe_6_n_o = 1'b1;
         pin_select_pkg::SEL_F3: row_strobe_6_n_o = mem_window_select_0_n;
         default: row_strobe_6_n_o = gen_out_reg[pin_select_pkg::GO_ROW6_POS];
      endcase
      case (sel_row7)
         pin_select_pkg::SEL_F1: row_strobe_7_n_o = core_out_i.row_strobe_7_n;
         pin_select_pkg::SEL_F2: row_strobe_7_n_o = companion_io_select_n;
         pin_select_pkg::SEL_F3: row_strobe_7_n_o = mem_window_select_1_n;
         default: row_strobe_7_n_o = gen_out_reg[pin_select_pkg::GO_ROW7_POS];
      endcase
      case (sel_flush)
         pin_select_pkg::SEL_F1: cache_flush_n_o = core_out_i.cache_flush_n;
         pin_select_pkg::SEL_F2: cache_flush_n_o = 1'b1;
         pin_select_pkg::SEL_F3: cache_flush_n_o = core_out_i.io_window_select_0_n;
         default: cache_flush_n_o = gen_out_reg[pin_select_pkg::GO_FLUSH_POS];
      endcase
   end

   // clock stop pin: power control picks request or speed select
   assign clock_stop_n_o = clock_stop_uses_speed_i ? slow_clock_active_i
                                                   : core_out_i.clock_stop_req_n;

   // open-collector mouse lines only drive low, only when enabled
   assign mouse_clock_line_o = 1'b0;
   assign mouse_data_line_o = 1'b0;
   assign mouse_clock_line_oe_o = mouse_enable_i && mouse_clock_drive_low_i;
   assign mouse_data_line_oe_o = mouse_enable_i && mouse_data_drive_low_i;
   assign mouse_clock_level_o = mclk_s;
   assign mouse_data_level_o = mouse_data_line_s;
endmodule

// >>> rtl/pin_select_pkg.sv
package pin_select_pkg;
   // register indexes
   localparam logic [7:0] SELECT_A_IDX = 8'h3c;
   localparam logic [7:0] SELECT_B_IDX = 8'h3d;
   localparam logic [7:0] GEN_OUT_IDX = 8'h3e;
   localparam logic [7:0] GEN_IN_IDX = 8'h3f;

   // reset values
   localparam logic [7:0] SELECT_A_RESET = 8'h00;
   localparam logic [7:0] SELECT_B_RESET = 8'h00;
   localparam logic [7:0] GEN_OUT_RESET = 8'h3f;

   // field positions in select a
   localparam int CLAIM1_SEL_POS = 0;
   localparam int CLAIM2_SEL_POS = 2;
   localparam int PIN_A_SEL_POS = 4;
   localparam int PIN_B_SEL_POS = 6;
   // field positions in select b
   localparam int ROW6_SEL_POS = 0;
   localparam int ROW7_SEL_POS = 2;
   localparam int PIN_C_SEL_POS = 4;
   localparam int PIN_D_SEL_POS = 6;
   // general output register
   localparam int GO_ROW6_POS = 0;
   localparam int GO_ROW7_POS = 1;
   localparam int GO_PIN_B_POS = 2;
   localparam int GO_PIN_C_POS = 3;
   localparam int GO_PIN_D_POS = 4;
   localparam int GO_FLUSH_POS = 5;
   localparam int FLUSH_SEL_POS = 6;
   // general input register
   localparam int GI_CLAIM0_POS = 0;
   localparam int GI_CLAIM1_POS = 1;
   localparam int GI_PIN_A_POS = 2;
   localparam int GI_MCLK_POS = 4;
   localparam int GI_MOUSE_DATA_LINE_POS = 5;

   typedef enum logic [1:0] {
      SEL_F1 = 2'b00,
      SEL_F2 = 2'b01,
      SEL_F3 = 2'b10,
      SEL_F4 = 2'b11
   } sel_code_e;

   // internal functions offered to the output pins
   typedef struct packed {
      logic writeback_policy;
      logic write_protect_n;
      logic cache_ram_select;
      logic dram_buffer_select_n;
      logic row_strobe_6_n;
      logic row_strobe_7_n;
      logic cache_flush_n;
      logic clock_stop_req_n;
      logic mouse_interrupt;
      logic mem_decode_0;
      logic mem_decode_1;
      logic io_window_select_0_n;
      logic io_window_select_1_n;
   } core_out_s;

   // values seen by the core from the input pins
   typedef struct packed {
      logic local_claim;
      logic time_base;
      logic time_base_valid;
      logic keyboard_lock;
      logic onboard_io_route_n;
      logic wake_event_0;
      logic wake_event_1;
   } core_in_s;
endpackage

// >>> testbench/multifunction_pin_select_monitor.sv
module multifunction_pin_select_monitor (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   input wire logic [7:0] reg_rdata_o,
   input wire pin_select_pkg::core_out_s core_out_i,
   input wire logic slow_clock_active_i,
   input wire logic clock_stop_uses_speed_i,
   input wire logic mouse_enable_i,
   input wire logic mouse_clock_drive_low_i,
   input wire logic mouse_clock_line_oe_o,
   input wire logic [15:10] cycle_addr_i,
   input wire logic local_claim_0_n_i,
   input wire logic multi_pin_a_i,
   input wire logic row_strobe_6_n_o,
   input wire logic row_strobe_7_n_o,
   input wire logic cache_flush_n_o,
   input wire logic clock_stop_n_o,
   input wire logic slow_clock_select_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] sel_b_reg;
   logic [7:0] gout_reg;
   // shadow of select b and the general output register
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sel_b_reg <= 8'h00;
         gout_reg <= 8'h3f;
      end else if (reg_write_i) begin
         if (reg_addr_i == 8'h3d) sel_b_reg <= reg_wdata_i;
         if (reg_addr_i == 8'h3e) gout_reg <= reg_wdata_i;
      end
   end
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!resetn_i);
   sequence s_pins_still;
      ($stable(local_claim_0_n_i) && $stable(multi_pin_a_i))[*4];
   endsequence
   sequence s_read_in;
      reg_read_i && reg_addr_i == 8'h3f;
   endsequence
   a_input_live: assert property (s_pins_still ##0 s_read_in |=>
      reg_rdata_o[7:6] == 2'b00 && !reg_rdata_o[3] && reg_rdata_o[2] == $past(multi_pin_a_i)
      && reg_rdata_o[0] == $past(local_claim_0_n_i)) else $error("input read wrong");
   a_read_gout: assert property ((reg_read_i && reg_addr_i == 8'h3e) |=>
      reg_rdata_o == gout_reg) else $error("output reg read wrong");
   a_rdata_idle: assert property (!reg_read_i |=> reg_rdata_o == 8'h00)
      else $error("read data not idle");
   a_companion_low: assert property (sel_b_reg[3:2] == 2'b01 |->
      row_strobe_7_n_o == (cycle_addr_i != 6'h00)) else $error("companion select wrong");
   a_mem_window: assert property (sel_b_reg[1:0] == 2'b10 |->
      row_strobe_6_n_o == !core_out_i.mem_decode_0) else $error("memory window wrong");
   a_reserved_high: assert property ((sel_b_reg[1:0] == 2'b01 || gout_reg[7:6] == 2'b01) |->
      (row_strobe_6_n_o || sel_b_reg[1:0] != 2'b01) && (cache_flush_n_o || gout_reg[7:6] != 2'b01))
      else $error("reserved code not high");
   a_general_output_drive: assert property (sel_b_reg[3:2] == 2'b11 |->
      row_strobe_7_n_o == gout_reg[1]) else $error("general output wrong");
   a_slow_select: assert property (slow_clock_select_o == slow_clock_active_i &&
      (!clock_stop_uses_speed_i || clock_stop_n_o == slow_clock_active_i)) else $error("slow sel");
   a_mouse_oc: assert property (mouse_clock_line_oe_o ==
      (mouse_enable_i && mouse_clock_drive_low_i)) else $error("mouse enable wrong");
endmodule

bind multifunction_pin_select multifunction_pin_select_monitor i_monitor (.clock_i, .resetn_i,
   .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .core_out_i,
   .slow_clock_active_i, .clock_stop_uses_speed_i, .mouse_enable_i, .mouse_clock_drive_low_i,
   .mouse_clock_line_oe_o, .cycle_addr_i, .local_claim_0_n_i, .multi_pin_a_i,
   .row_strobe_6_n_o, .row_strobe_7_n_o, .cache_flush_n_o, .clock_stop_n_o, .slow_clock_select_o);

// >>> testbench/pin_partner.sv
module pin_partner (
   input wire logic [3:0] level_i,
   input wire logic dma_req_i,
   input wire logic mouse_clock_oe_i,
   input wire logic mouse_data_oe_i,
   input wire logic keyboard_lock_i,
   output logic [3:0] pin_o,
   output logic dma_grant_n_o,
   output logic mouse_clock_o,
   output logic mouse_data_o,
   output logic key_taken_o
);
   timeunit 1ns;
   timeprecision 100ps;
   assign pin_o = level_i;
   assign dma_grant_n_o = !dma_req_i;
   // pulled up unless the device sinks the line
   assign mouse_clock_o = !mouse_clock_oe_i;
   assign mouse_data_o = !mouse_data_oe_i;
   // keystrokes refused while locked
   assign key_taken_o = keyboard_lock_i;
endmodule

// >>> testbench/multifunction_pin_select_tb.sv
`define CHECK(nm, ex, got) begin \
   samples_checked++; \
   if ((got) !== (ex)) begin \
      error_cnt++; \
      $display("wrong value %s expected %h seen %h", nm, (ex), (got)); \
   end \
end
module multifunction_pin_select_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic slow = 1'b0;
   logic stop_sel = 1'b0;
   logic m_en = 1'b0;
   logic m_low = 1'b0;
   logic exp_act = 1'b0;
   logic dma_req = 1'b0;
   logic [15:10] cyc = 6'h10;
   logic [3:0] level = 4'hf;
   pin_select_pkg::core_out_s co = '1;
   pin_select_pkg::core_in_s ci;
   pin_select_pkg::core_in_s ce;
   logic [7:0] rdata;
   logic [3:0] pin_w, lv;
   logic dma_grant_n_n, mclk_w, mdat_w, mclk_oe, mdat_oe, io_onb, mclk_lvl, mdat_lvl, slow_sel;
   logic pin_b, pin_c, pin_d, row6, row7, flush, stop_n;
   int error_cnt = 0;
   int samples_checked = 0;
   int cycles = 0;
   wire [5:0] pins = {flush, pin_d, pin_c, pin_b, row7, row6};

   multifunction_pin_select i_multifunction_pin_select (
      .clock_i(clock_i), .resetn_i(resetn_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_write_i(wr_s), .reg_read_i(rd_s), .reg_rdata_o(rdata), .core_out_i(co),
      .core_in_o(ci), .slow_clock_active_i(slow), .clock_stop_uses_speed_i(stop_sel),
      .mouse_enable_i(m_en), .mouse_clock_drive_low_i(m_low), .mouse_data_drive_low_i(1'b0),
      .mouse_clock_level_o(mclk_lvl), .mouse_data_level_o(mdat_lvl), .cycle_addr_i(cyc),
      .expansion_cycle_active_i(exp_act), .io_cycle_i(1'b1), .io_to_onboard_bus_o(io_onb),
      .local_claim_0_n_i(pin_w[0]), .local_claim_1_n_i(pin_w[1]), .local_claim_2_n_i(pin_w[2]),
      .multi_pin_a_i(pin_w[3]), .dma_grant_n_i(dma_grant_n_n), .mouse_clock_line_i(mclk_w),
      .mouse_clock_line_o(), .mouse_clock_line_oe_o(mclk_oe), .mouse_data_line_i(mdat_w),
      .mouse_data_line_o(), .mouse_data_line_oe_o(mdat_oe), .multi_pin_b_o(pin_b),
      .multi_pin_c_o(pin_c), .multi_pin_d_o(pin_d), .row_strobe_6_n_o(row6),
      .row_strobe_7_n_o(row7), .cache_flush_n_o(flush), .clock_stop_n_o(stop_n),
      .slow_clock_select_o(slow_sel));
   pin_partner i_pin_partner (.level_i(level), .dma_req_i(dma_req), .mouse_clock_oe_i(mclk_oe),
      .mouse_data_oe_i(mdat_oe), .keyboard_lock_i(ci.keyboard_lock), .pin_o(pin_w),
      .dma_grant_n_o(dma_grant_n_n), .mouse_clock_o(mclk_w), .mouse_data_o(mdat_w), .key_taken_o());

   initial forever #12.5 clock_i = ~clock_i;

   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock_i);
      wr_s <= 1'b0;
   endtask
   task automatic read_reg(input logic [7:0] a, input logic [7:0] ex);
      @(posedge clock_i);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clock_i);
      rd_s <= 1'b0;
      @(negedge clock_i);
      `CHECK("read data", ex, rdata)
   endtask
   // pins {flush, d, c, b, row7, row6} for one code on every select
   function automatic logic [5:0] exp_pins(input logic [1:0] k, input pin_select_pkg::core_out_s c);
      case (k)
         2'b00: return {c.cache_flush_n, c.dram_buffer_select_n, c.write_protect_n,
            c.writeback_policy, c.row_strobe_7_n, c.row_strobe_6_n};
         2'b01: return {1'b1, exp_act, c.cache_ram_select, exp_act, |cyc, 1'b1};
         2'b10: return {c.io_window_select_0_n, c.io_window_select_1_n, c.io_window_select_0_n,
            c.mouse_interrupt, !c.mem_decode_1, !c.mem_decode_0};
         default: return 6'h15;
      endcase
   endfunction
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         complete_run();
      end
   end

   initial begin
      repeat (5) @(posedge clock_i);
      resetn_i <= 1'b1;
      read_reg(8'h3c, 8'h00);
      read_reg(8'h3d, 8'h00);
      read_reg(8'h3e, 8'h3f);
      read_reg(8'h3f, 8'h37);
      read_reg(8'h40, 8'h00);
      `CHECK("pins after reset", 6'h3f, pins)
      $display("test reset done");
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 4; k++) begin
            write_reg(8'h3c, {k[1:0], 6'h00});
            write_reg(8'h3d, {4{k[1:0]}});
            write_reg(8'h3e, {k[1:0], 6'h15});
            co <= p ? 13'h0a5a : 13'h15a5;
            exp_act <= p[0];
            cyc <= p ? 6'h00 : 6'h10;
            @(negedge clock_i);
            `CHECK("pin mux", exp_pins(k[1:0], co), pins)
         end
      end
      write_reg(8'h3d, 8'hff);
      for (int i = 0; i < 6; i++) begin
         write_reg(8'h3e, 8'hc0 | (8'h01 << i));
         @(negedge clock_i);
         `CHECK("general outputs", 6'h01 << i, pins)
      end
      write_reg(8'h3f, 8'h00);
      read_reg(8'h3e, 8'he0);
      write_reg(8'h3c, 8'h40);
      exp_act <= 1'b0;
      for (int v = 1; v >= 0; v--) begin
         @(posedge clock_i);
         dma_req <= v[0];
         repeat (3) @(posedge clock_i);
         @(negedge clock_i);
         `CHECK("expansion enable", v[0], pin_b)
      end
      $display("test outputs done");
      for (int k = 0; k < 4; k++) begin
         for (int j = 0; j < 3; j++) begin
            lv = (j == 0) ? 4'h0 : (j == 1) ? 4'hf : 4'hd;
            write_reg(8'h3c, {2'b00, {3{k[1:0]}}});
            level <= lv;
            repeat (3) @(posedge clock_i);
            @(negedge clock_i);
            ce.local_claim = !lv[0] || (k == 1 && !(lv[1] && lv[2]));
            ce.time_base = (k == 2) ? lv[1] : (k == 1) && lv[3];
            ce.time_base_valid = (k == 1 || k == 2);
            ce.keyboard_lock = (k == 2) ? lv[2] : 1'b1;
            ce.onboard_io_route_n = (k == 2) ? lv[3] : 1'b1;
            ce.wake_event_0 = (k == 3) && lv[3];
            ce.wake_event_1 = (k == 3) && lv[2];
            `CHECK("core inputs", ce, ci)
            `CHECK("onboard io", (k == 2) && !lv[3], io_onb)
            read_reg(8'h3f, {4'h3, 1'b0, lv[3], lv[1:0]});
         end
      end
      $display("test inputs done");
      @(posedge clock_i);
      m_en <= 1'b1;
      m_low <= 1'b1;
      slow <= 1'b1;
      stop_sel <= 1'b1;
      repeat (3) @(posedge clock_i);
      @(negedge clock_i);
      `CHECK("mouse clock level", 1'b0, mclk_lvl)
      `CHECK("mouse data level", 1'b1, mdat_lvl)
      `CHECK("clock stop pin", 1'b1, stop_n)
      `CHECK("slow clock select", 1'b1, slow_sel)
      read_reg(8'h3f, 8'h25);
      $display("test mouse and clock done");
      complete_run();
   end
endmodule
